// ==== twm_pkg.sv ====
package twm_pkg;

   // Timing of the master clock
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned MAX_SCL_HZ     = 400_000;
   localparam int unsigned MIN_PERIOD_CYC = (CLK_HZ + MAX_SCL_HZ - 1) / MAX_SCL_HZ;
   localparam logic [16:0] MIN_LOW_CYC    = 17'((MIN_PERIOD_CYC + 1) / 2);
   localparam logic [16:0] MIN_HIGH_CYC   = 17'(MIN_PERIOD_CYC / 2);
   localparam logic [16:0] LOW_EXTRA      = 17'h2;
   localparam logic [16:0] HIGH_EXTRA     = 17'h3;
   localparam logic [16:0] HOLD_EXTRA     = 17'h4;

   // Register offsets
   localparam logic [7:0] OFS_DATA       = 8'h00;
   localparam logic [7:0] OFS_STATUS     = 8'h08;
   localparam logic [7:0] OFS_OWN_ADDR   = 8'h0c;
   localparam logic [7:0] OFS_CONTROL    = 8'h14;
   localparam logic [7:0] OFS_LOW_TIME   = 8'h18;
   localparam logic [7:0] OFS_HIGH_TIME  = 8'h1c;
   localparam logic [7:0] OFS_HOLD_TIME  = 8'h20;
   localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h24;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;

   // Reset values
   localparam logic [7:0]  DATA_RST    = 8'hff;
   localparam logic [7:0]  OWN_RST     = 8'h00;
   localparam logic [15:0] LOW_RST     = 16'hffff;
   localparam logic [15:0] HIGH_RST    = 16'hffff;
   localparam logic [14:0] HOLD_RST    = 15'h7fff;
   localparam logic [7:0]  IRQ_EN_RST  = 8'hff;

   // Control field positions
   localparam int unsigned CTL_START   = 0;
   localparam int unsigned CTL_STOP    = 1;
   localparam int unsigned CTL_ACKEN   = 3;
   localparam int unsigned CTL_INTEN   = 4;
   localparam int unsigned CTL_SOFTRST = 5;
   localparam int unsigned CTL_IIF     = 7;

   // Status bits: sticky ones, and those a status write clears
   localparam logic [7:0] STICKY_MASK   = 8'hf9;
   localparam logic [7:0] STAT_WR_CLEAR = 8'h79;
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;

   // Status layout, bit 7 down to bit 0
   typedef struct packed {
      logic general_call_or_addr_ack_flag;
      logic byte_tx_done_flag;
      logic stop_flag;
      logic slave_sel_flag;
      logic arbitration_lost_flag;
      logic busy_flag;
      logic tx_direction_flag;
      logic ack_received_flag;
   } twm_status_s;

   // Engine states, consecutive Gray codes in the order listed
   typedef enum logic [3:0] {
      TWM_IDLE   = 4'h0,
      TWM_START  = 4'h1,
      TWM_LOW    = 4'h3,
      TWM_HIGH   = 4'h2,
      TWM_WAIT   = 4'h6,
      TWM_STOP_L = 4'h7,
      TWM_STOP_H = 4'h5,
      TWM_SLAVE  = 4'h4
   } twm_state_e;

endpackage : twm_pkg

// ==== twm_line_sync.sv ====
`timescale 1ns/1ns
module twm_line_sync #(
   parameter int unsigned W = 2
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic         ce,
   // Lines in and out
   input  wire logic [W-1:0] line_in,
   output logic      [W-1:0] line_out
);

   logic [W-1:0] stage1;

   // Two flops per line, idle level high
   for (genvar i = 0; i < W; i++) begin : g_sync
      always_ff @(posedge core_clk) begin
         if (!rst_b) begin
            stage1[i]   <= 1'b1;
            line_out[i] <= 1'b1;
         end else if (ce) begin
            stage1[i]   <= line_in[i];
            line_out[i] <= stage1[i];
         end
      end
   end

endmodule : twm_line_sync

// ==== twm_port.sv ====
// Local design decision: the APB slave port.
`timescale 1ns/1ns
module twm_port import twm_pkg::*; (
   // Clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Open-drain bus lines
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   // Interrupt
   output logic             irq
);

   // Decode of implemented offsets
   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         OFS_DATA, OFS_STATUS, OFS_OWN_ADDR, OFS_CONTROL, OFS_LOW_TIME,
         OFS_HIGH_TIME, OFS_HOLD_TIME, OFS_IRQ_CLEAR, OFS_IRQ_ENABLE: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   // Phase length: register count plus added clocks
   function automatic logic [16:0] phase_len(input logic [15:0] c, input logic [16:0] add);
      logic [16:0] s;
      s = {1'b0, c} + add;
      phase_len = s;
   endfunction : phase_len

   logic [7:0]  shift_byte;
   logic [6:0]  own_slave_address;
   logic        general_call_accept;
   logic        ctl_start;
   logic        ctl_stop;
   logic        ctl_acken;
   logic        ctl_inten;
   logic        ctl_softrst;
   logic [15:0] clock_low_count;
   logic [15:0] clock_high_count;
   logic [14:0] data_hold_count;
   logic [7:0]  irq_enable;
   twm_status_s flags;
   twm_status_s ev;
   twm_status_s status_view;
   twm_state_e  state;
   logic [16:0] cnt;
   logic [3:0]  bit_cnt;
   logic        addr_phase;
   logic        is_master;
   logic        tx_dir;
   logic        busy;
   logic        ack_seen;
   logic [1:0]  lines_s;
   logic        scl_s;
   logic        sda_s;
   logic        scl_q;
   logic        sda_q;
   logic [31:0] rd_mux;
   logic [16:0] low_len;
   logic [16:0] high_len;
   logic [16:0] hold_raw;
   logic [16:0] hold_pt;

   wire setup    = psel & ~penable;
   wire wr_en    = psel & penable & pready & pwrite & is_mapped(paddr);
   wire wr_data  = wr_en & (paddr == OFS_DATA);
   wire st_wr    = wr_en & (paddr == OFS_STATUS);
   wire start_go = ce & (state == TWM_IDLE) & ctl_start & ~busy & ~ctl_softrst;
   wire stop_go  = ce & (state == TWM_WAIT) & st_wr & is_master & ctl_stop;

   // Bus conditions seen on the synchronised lines
   wire scl_rise  = scl_s & ~scl_q;
   wire scl_fall  = ~scl_s & scl_q;
   wire start_det = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;
   wire [6:0] rx_addr = shift_byte[7:1];
   wire gc_hit    = general_call_accept & (rx_addr == GEN_CALL_ADDR);
   wire addr_hit  = (rx_addr == own_slave_address) | gc_hit;

   twm_line_sync #(.W(2)) u_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .line_in  ({scl_i, sda_i}),
      .line_out (lines_s)
   );
   assign scl_s = lines_s[1];
   assign sda_s = lines_s[0];

   // Phase lengths, clamped to the fastest legal rate
   always_comb begin
      low_len  = phase_len(clock_low_count, LOW_EXTRA);
      high_len = phase_len(clock_high_count, HIGH_EXTRA);
      if (low_len < MIN_LOW_CYC) low_len = MIN_LOW_CYC;
      if (high_len < MIN_HIGH_CYC) high_len = MIN_HIGH_CYC;
      hold_raw = {2'b00, data_hold_count} + HOLD_EXTRA;
      hold_pt  = (hold_raw >= low_len - 17'h1) ? low_len - 17'h2 : hold_raw;
   end

   // Status as software sees it
   always_comb begin
      status_view                   = flags;
      status_view.busy_flag         = busy;
      status_view.tx_direction_flag = tx_dir;
   end

   // Read data selection
   always_comb begin
      case (paddr)
         OFS_DATA:       rd_mux = {24'h0, shift_byte};
         OFS_STATUS:     rd_mux = {24'h0, status_view};
         OFS_OWN_ADDR:   rd_mux = {24'h0, own_slave_address, general_call_accept};
         OFS_CONTROL:    rd_mux = {24'h0, irq, 1'b0, ctl_softrst, ctl_inten, ctl_acken,
                                   1'b0, ctl_stop, ctl_start};
         OFS_LOW_TIME:   rd_mux = {16'h0, clock_low_count};
         OFS_HIGH_TIME:  rd_mux = {16'h0, clock_high_count};
         OFS_HOLD_TIME:  rd_mux = {17'h0, data_hold_count};
         OFS_IRQ_ENABLE: rd_mux = {24'h0, irq_enable};
         default:        rd_mux = 32'h0;
      endcase
   end

   // APB answer, one wait-free access phase
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= setup;
         // Error stands only with the one-cycle answer
         pslverr <= setup & ~is_mapped(paddr);
         if (setup) begin
            prdata  <= pwrite ? 32'h0 : rd_mux;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         {own_slave_address, general_call_accept} <= OWN_RST;
         {ctl_start, ctl_stop, ctl_acken, ctl_inten, ctl_softrst} <= 5'h0;
         clock_low_count  <= LOW_RST;
         clock_high_count <= HIGH_RST;
         data_hold_count  <= HOLD_RST;
         irq_enable       <= IRQ_EN_RST;
      end else if (ce) begin
         if (start_go) ctl_start <= 1'b0;
         if (stop_go) ctl_stop <= 1'b0;
         if (wr_en) begin
            case (paddr)
               OFS_OWN_ADDR: {own_slave_address, general_call_accept} <= pwdata[7:0];
               OFS_CONTROL: begin
                  ctl_start   <= pwdata[CTL_START];
                  ctl_stop    <= pwdata[CTL_STOP];
                  ctl_acken   <= pwdata[CTL_ACKEN];
                  ctl_inten   <= pwdata[CTL_INTEN];
                  ctl_softrst <= pwdata[CTL_SOFTRST];
               end
               OFS_LOW_TIME:   clock_low_count  <= pwdata[15:0];
               OFS_HIGH_TIME:  clock_high_count <= pwdata[15:0];
               OFS_HOLD_TIME:  data_hold_count  <= pwdata[14:0];
               OFS_IRQ_ENABLE: irq_enable       <= pwdata[7:0];
               default: ;
            endcase
         end
      end
   end

   // Sticky flags, a new event beats a clear
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         flags <= '0;
      end else if (ce) begin
         flags <= (flags & ~((st_wr ? STAT_WR_CLEAR : 8'h00)
                  | ((wr_en && paddr == OFS_IRQ_CLEAR) ? pwdata[7:0] : 8'h00)))
                  | (ev & STICKY_MASK);
      end
   end

   // Interrupt line
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= ctl_inten & |(flags & irq_enable & STICKY_MASK);
      end
   end

   // Previous line levels for edge detection
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else if (ce) begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // Protocol engine
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state      <= TWM_IDLE;
         cnt        <= 17'h0;
         bit_cnt    <= 4'h0;
         addr_phase <= 1'b0;
         is_master  <= 1'b0;
         tx_dir     <= 1'b0;
         busy       <= 1'b0;
         ack_seen   <= 1'b0;
         scl_oe     <= 1'b0;
         sda_oe     <= 1'b0;
         ev         <= '0;
         shift_byte <= DATA_RST;
      end else if (ce) begin
         ev <= '0;
         if (wr_data) shift_byte <= pwdata[7:0];
         if (start_det) busy <= 1'b1;
         if (stop_det) busy <= 1'b0;
         // bit capture on each rising clock in TWM_HIGH or TWM_SLAVE
         if (scl_rise && state inside {TWM_HIGH, TWM_SLAVE}) begin
            if (bit_cnt < 4'h8) shift_byte <= {shift_byte[6:0], sda_s};
            else ack_seen <= ~sda_s;
         end
         if (ctl_softrst) begin
            state     <= TWM_IDLE;
            is_master <= 1'b0;
            scl_oe    <= 1'b0;
            sda_oe    <= 1'b0;
         end else if (stop_det) begin
            ev.stop_flag <= 1'b1;
            state        <= TWM_IDLE;
            is_master    <= 1'b0;
            scl_oe       <= 1'b0;
            sda_oe       <= 1'b0;
         end else if (start_det && !is_master) begin
            // join as slave on a foreign start
            state      <= TWM_SLAVE;
            bit_cnt    <= 4'h0;
            addr_phase <= 1'b1;
            tx_dir     <= 1'b0;
            sda_oe     <= 1'b0;
         end else if (is_master && scl_rise && state == TWM_HIGH && bit_cnt < 4'h8
                      && tx_dir && !sda_oe && !sda_s) begin
            ev.arbitration_lost_flag <= 1'b1;
            state     <= TWM_IDLE;
            is_master <= 1'b0;
            scl_oe    <= 1'b0;
         end else begin
            case (state)
               TWM_IDLE: begin
                  scl_oe <= 1'b0;
                  sda_oe <= 1'b0;
                  if (start_go) begin
                     state      <= TWM_START;
                     sda_oe     <= 1'b1;
                     cnt        <= 17'h0;
                     bit_cnt    <= 4'h0;
                     is_master  <= 1'b1;
                     tx_dir     <= 1'b1;
                     addr_phase <= 1'b1;
                  end
               end
               TWM_START: begin
                  cnt <= cnt + 17'h1;
                  if (cnt == high_len - 17'h1) begin
                     state  <= TWM_LOW;
                     scl_oe <= 1'b1;
                     cnt    <= 17'h0;
                  end
               end
               TWM_LOW: begin
                  cnt <= cnt + 17'h1;
                  if (cnt == hold_pt) begin
                     if (bit_cnt < 4'h8) sda_oe <= tx_dir & ~shift_byte[7];
                     else sda_oe <= ~tx_dir & ctl_acken;
                  end
                  if (cnt == low_len - 17'h1) begin
                     state  <= TWM_HIGH;
                     scl_oe <= 1'b0;
                     cnt    <= 17'h0;
                  end
               end
               TWM_HIGH: begin
                  if (scl_s) cnt <= cnt + 17'h1;
                  if (scl_s && cnt == high_len - 17'h1) begin
                     scl_oe <= 1'b1;
                     cnt    <= 17'h0;
                     if (bit_cnt == 4'h8) begin
                        state                <= TWM_WAIT;
                        ev.byte_tx_done_flag <= 1'b1;
                        ev.ack_received_flag <= ack_seen;
                        if (addr_phase) begin
                           ev.general_call_or_addr_ack_flag <= ack_seen;
                           tx_dir <= ~shift_byte[0];
                        end
                        addr_phase <= 1'b0;
                     end else begin
                        state   <= TWM_LOW;
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               TWM_WAIT: begin
                  scl_oe <= 1'b1;
                  if (st_wr) begin
                     bit_cnt <= 4'h0;
                     cnt     <= 17'h0;
                     if (!is_master) begin
                        state  <= TWM_SLAVE;
                        scl_oe <= 1'b0;
                        sda_oe <= tx_dir & ~shift_byte[7];
                     end else if (ctl_stop) begin
                        state  <= TWM_STOP_L;
                        sda_oe <= 1'b1;
                     end else begin
                        state <= TWM_LOW;
                     end
                  end
               end
               TWM_STOP_L: begin
                  cnt <= cnt + 17'h1;
                  if (cnt == low_len - 17'h1) begin
                     state  <= TWM_STOP_H;
                     scl_oe <= 1'b0;
                     cnt    <= 17'h0;
                  end
               end
               TWM_STOP_H: begin
                  if (scl_s) cnt <= cnt + 17'h1;
                  if (scl_s && cnt == high_len - 17'h1) begin
                     state     <= TWM_IDLE;
                     sda_oe    <= 1'b0;
                     is_master <= 1'b0;
                  end
               end
               TWM_SLAVE: begin
                  if (scl_fall) begin
                     if (bit_cnt == 4'h8) begin
                        state                <= TWM_WAIT;
                        scl_oe               <= 1'b1;
                        sda_oe               <= 1'b0;
                        addr_phase           <= 1'b0;
                        ev.byte_tx_done_flag <= 1'b1;
                        ev.ack_received_flag <= ack_seen;
                     end else if (bit_cnt == 4'h7) begin
                        bit_cnt <= 4'h8;
                        if (!addr_phase) begin
                           sda_oe <= ~tx_dir & ctl_acken;
                        end else if (addr_hit) begin
                           sda_oe                           <= 1'b1;
                           tx_dir                           <= shift_byte[0];
                           ev.slave_sel_flag                <= 1'b1;
                           ev.general_call_or_addr_ack_flag <= gc_hit;
                        end else begin
                           state  <= TWM_IDLE;
                           sda_oe <= 1'b0;
                        end
                     end else begin
                        bit_cnt <= bit_cnt + 4'h1;
                        sda_oe  <= tx_dir & ~addr_phase & ~shift_byte[7];
                     end
                  end
               end
               default: state <= TWM_IDLE;
            endcase
         end
      end
   end

endmodule : twm_port

// ==== twm_port_props.sv ====
`timescale 1ns/1ns
module twm_port_props import twm_pkg::*; (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic        ce,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Lines and interrupt
   input wire logic        scl_o,
   input wire logic        scl_oe,
   input wire logic        sda_o,
   input wire logic        sda_oe,
   input wire logic        irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Offsets that answer without error
   logic mapped;
   assign mapped = paddr inside {OFS_DATA, OFS_STATUS, OFS_OWN_ADDR, OFS_CONTROL,
      OFS_LOW_TIME, OFS_HIGH_TIME, OFS_HOLD_TIME, OFS_IRQ_CLEAR, OFS_IRQ_ENABLE};
   a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
      else $error("ready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_unmapped: assert property (pready && psel && !mapped |-> pslverr)
      else $error("unmapped offset accepted");
   a_err_only_unmapped: assert property (pslverr |-> pready && !mapped)
      else $error("error on mapped offset");
   a_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   a_lines_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
      else $error("bus line driven high");
   a_low_phase_min: assert property ($rose(scl_oe) |=> scl_oe [*8])
      else $error("clock low phase too short");
   a_high_phase_min: assert property ($fell(scl_oe) |=> !scl_oe [*8])
      else $error("clock high phase too short");
   a_reset_quiet: assert property (disable iff (1'b0)
      !rst_b |=> !irq && !scl_oe && !sda_oe && !pready) else $error("outputs busy in reset");
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
   c_held: cover property (scl_oe [*8]);
endmodule : twm_port_props
bind twm_port twm_port_props u_props (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
   .sda_oe(sda_oe), .irq(irq));

// ==== twm_bus_model.sv ====
`timescale 1ns/1ns
module twm_bus_model #(
   parameter logic [6:0] ADDR = 7'h5a
) (
   // Bus line levels
   input  wire logic  scl,
   input  wire logic  sda,
   // Data pull and last byte taken
   output logic       sda_low,
   output logic [7:0] last_byte
);
   int         nbit  = 0;
   logic       act   = 1'b0;
   logic       first = 1'b0;
   logic [7:0] shf   = 8'h00;
   initial begin
      sda_low = 1'b0;
      last_byte = 8'h00;
   end
   // start opens a frame, stop closes it
   always @(sda) begin
      if (scl === 1'b1) begin
         act = !sda;
         first = 1'b1;
         nbit = 0;
      end
   end
   // Capture MSB first on rising clock
   always @(posedge scl) begin
      if (act) begin
         if (nbit < 8) shf = {shf[6:0], sda};
         nbit = nbit + 1;
      end
   end
   // acknowledge own address and every data byte
   always @(negedge scl) begin
      if (act && nbit == 8) begin
         last_byte = shf;
         sda_low = !first || shf[7:1] == ADDR;
         first = 1'b0;
      end else if (nbit == 9) begin
         sda_low = 1'b0;
         nbit = 0;
      end
   end
endmodule : twm_bus_model

// ==== twm_port_bench.sv ====
`timescale 1ns/1ns
module twm_port_bench import twm_pkg::*; ;
   logic        core_clk = 1'b0;
   logic        rst_b    = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, scl_oe, sda_oe, sda_low, irq, err;
   logic [7:0]  seen;
   logic        m_scl    = 1'b0;
   logic        m_sda    = 1'b0;
   wire         scl = !(scl_oe || m_scl);
   wire         sda = !(sda_oe || sda_low || m_sda);
   int          n_fail = 0;
   int          n_tests = 0;
   always #50 core_clk = ~core_clk;
   twm_port dut (.core_clk(core_clk), .rst_b(rst_b), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .irq(irq));
   twm_bus_model #(.ADDR(7'h5a)) peer (.scl(scl), .sda(sda), .sda_low(sda_low),
      .last_byte(seen));
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : check
   // One APB transfer, held until ready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e);
   endtask : rd_chk
   task automatic irq_is(input logic e);
      repeat (2) @(posedge core_clk);
      check({31'h0, irq}, {31'h0, e});
   endtask : irq_is
   task automatic wait_irq();
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 3000) begin
         @(posedge core_clk);
         k++;
      end
      check({31'h0, irq}, 32'h1);
   endtask : wait_irq
   // Bench as bus master: one bit, clock pulled low again after it
   task automatic m_bit(input logic b);
      m_sda <= ~b;
      repeat (4) @(posedge core_clk);
      m_scl <= 1'b0;
      repeat (4) @(posedge core_clk);
      m_scl <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask : m_bit
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   // Watchdog: the run needs under a thousand cycles
   initial begin
      #(100 * 20000);
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      // Reset values and refused offset
      rd_chk(OFS_DATA, 32'h0000_00ff);
      rd_chk(OFS_STATUS, 32'h0);
      rd_chk(OFS_OWN_ADDR, 32'h0);
      rd_chk(OFS_CONTROL, 32'h0);
      rd_chk(OFS_LOW_TIME, 32'h0000_ffff);
      rd_chk(OFS_HIGH_TIME, 32'h0000_ffff);
      rd_chk(OFS_HOLD_TIME, 32'h0000_7fff);
      rd_chk(8'h30, 32'h0);
      check({31'h0, err}, 32'h1);
      apb(1'b1, OFS_OWN_ADDR, 32'h0000_0035);
      rd_chk(OFS_OWN_ADDR, 32'h0000_0035);
      apb(1'b1, OFS_LOW_TIME, 32'h0000_0008);
      apb(1'b1, OFS_HIGH_TIME, 32'h0000_0008);
      apb(1'b1, OFS_HOLD_TIME, 32'h0000_0001);
      rd_chk(OFS_LOW_TIME, 32'h0000_0008);
      $display("test registers done");
      // Address byte, write direction, then clock held
      apb(1'b1, OFS_DATA, 32'h0000_00b4);
      apb(1'b1, OFS_CONTROL, 32'h0000_0011);
      wait_irq();
      check({31'h0, scl_oe}, 32'h1);
      rd_chk(OFS_STATUS, 32'h0000_00c7);
      check({24'h0, seen}, 32'h0000_00b4);
      // Interrupt masked and unmasked
      apb(1'b1, OFS_IRQ_ENABLE, 32'h0);
      irq_is(1'b0);
      apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_00ff);
      irq_is(1'b1);
      // Data byte after release
      apb(1'b1, OFS_DATA, 32'h0000_003c);
      apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_0080);
      apb(1'b1, OFS_STATUS, 32'h0);
      rd_chk(OFS_STATUS, 32'h0000_0006);
      wait_irq();
      rd_chk(OFS_STATUS, 32'h0000_0047);
      check({24'h0, seen}, 32'h0000_003c);
      $display("test transmit done");
      // Stop after the last byte
      apb(1'b1, OFS_CONTROL, 32'h0000_0012);
      apb(1'b1, OFS_STATUS, 32'h0);
      irq_is(1'b0);
      wait_irq();
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd & 32'h0000_0024, 32'h0000_0020);
      apb(1'b1, OFS_STATUS, 32'h0000_00ff);
      irq_is(1'b0);
      $display("test stop done");
      // Bench as master: general call address, port answers as slave
      m_sda <= 1'b1;
      repeat (4) @(posedge core_clk);
      m_scl <= 1'b1;
      repeat (2) @(posedge core_clk);
      repeat (8) m_bit(1'b0);
      m_bit(1'b1);
      repeat (4) @(posedge core_clk);
      rd_chk(OFS_STATUS, 32'h0000_00d5);
      rd_chk(OFS_DATA, 32'h0);
      check({31'h0, scl_oe}, 32'h1);
      apb(1'b1, OFS_STATUS, 32'h0);
      // Stop from the bench after the held clock is released
      m_sda <= 1'b1;
      repeat (4) @(posedge core_clk);
      m_scl <= 1'b0;
      repeat (4) @(posedge core_clk);
      m_sda <= 1'b0;
      repeat (8) @(posedge core_clk);
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd & 32'h0000_0024, 32'h0000_0020);
      $display("test slave done");
      give_verdict();
   end
endmodule : twm_port_bench
